/* rtl/fixed_point_shift_unit.sv */
// Fixed-point shift and rotate datapath: left shifts with and without quotient register,
// 64-bit algebraic right shifts, and the immediate algebraic right with quotient register.
// Assumes operands are valid in the cycle op_valid is high; results appear one cycle later.
`timescale 1ns/1ns
module fixed_point_shift_unit #(
	parameter bit IS_64BIT = 1'b1 // Implementation has 64-bit shifts
) (
	input wire logic ref_clk, // Core clock, 20 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic op_valid, // Operation present this cycle
	input wire shift_unit_pkg::shift_op_type op_code, // Decoded operation
	input wire logic record_bit, // Record form of the operation
	input wire logic [63:0] source_reg, // Source operand
	input wire logic [63:0] amount_reg, // Shift amount operand
	input wire logic [6:0] immediate_count, // Immediate shift count
	input wire logic summary_overflow_in, // Summary overflow from exception register
	output logic [63:0] dest_reg, // Result for destination
	output logic dest_we, // Destination write pulse
	output logic [31:0] multiply_quotient_reg, // Quotient register contents
	output logic shifted_out_flag, // Carry flag
	output logic carry_we, // Carry write pulse
	output logic [3:0] cond_field_zero, // Negative, positive, zero, summary overflow
	output logic cond_we, // Condition field write pulse
	output logic illegal_op // Illegal instruction pulse
);
	import shift_unit_pkg::*;

	logic [4:0] cnt5;
	logic mask_off;
	logic [31:0] left_mask;
	logic [31:0] rot_left;
	logic [31:0] rot_quot;
	logic [31:0] quot_mask;
	logic [6:0] dcount;
	logic [63:0] next_sra;
	logic next_sra_carry;
	logic [63:0] next_dest;
	logic next_carry;
	logic next_dest_we;
	logic next_carry_we;
	logic next_mq_we;
	logic next_illegal;
	logic [31:0] sign_word;

	// 32-bit rotate left, shared by both rotate paths
	function automatic logic [31:0] rotl32(input logic [31:0] v, input logic [4:0] n);
		logic [63:0] d;
		d = {v, v} << n;
		return d[63:32];
	endfunction : rotl32

	// Condition nibble: negative, positive, zero, summary overflow
	function automatic logic [3:0] cond_of(input logic [63:0] r, input logic so);
		logic neg;
		logic zer;
		neg = r[SIGN_BIT64];
		zer = (r == 64'h0000_0000_0000_0000);
		return {neg, !neg && !zer, zer, so};
	endfunction : cond_of

	// Amount register fields
	assign cnt5 = amount_reg[AMT_COUNT_LSB +: CNT_W];
	assign mask_off = amount_reg[AMT_MASKOFF_BIT];
	assign rot_left = rotl32(source_reg[31:0], cnt5);

	shift_mask_gen u_mask (
		.count(cnt5),
		.force_zero(mask_off),
		.mask(left_mask)
	);

	// Immediate quotient right: rotate by 32-N, mask of N zeros then 32-N ones
	assign rot_quot = rotl32(source_reg[31:0], 5'(QUOT_ROT_BASE - int'(immediate_count[4:0])));
	assign quot_mask = 32'hFFFF_FFFF >> immediate_count[4:0];
	assign sign_word = {WORD_W{source_reg[SIGN_BIT32]}};

	// Count source: register low seven bits or immediate
	assign dcount = (op_code == OP_SRA_DWORD_IMM) ? immediate_count :
		amount_reg[AMT_DCOUNT_LSB +: DCNT_W];

	// 64-bit algebraic right shift and its carry, mode-independent
	always_comb begin
		logic [127:0] ext;
		logic [63:0] lost;
		ext = {{64{source_reg[SIGN_BIT64]}}, source_reg};
		lost = 64'h0000_0000_0000_0000;
		if (dcount == 7'h00) begin
			next_sra = source_reg;
			next_sra_carry = 1'b0;
		end else if (dcount[6]) begin
			next_sra = {DWORD_W{source_reg[SIGN_BIT64]}};
			next_sra_carry = source_reg[SIGN_BIT64];
		end else begin
			next_sra = 64'(ext >> dcount[5:0]);
			lost = source_reg & ~(64'hFFFF_FFFF_FFFF_FFFF << dcount[5:0]);
			next_sra_carry = source_reg[SIGN_BIT64] && (|lost);
		end
	end

	// Result selection per operation
	always_comb begin
		next_dest = dest_reg;
		next_carry = shifted_out_flag;
		next_dest_we = 1'b0;
		next_carry_we = 1'b0;
		next_mq_we = 1'b0;
		next_illegal = 1'b0;
		if (op_valid) begin
			unique case (op_code)
				OP_SHIFT_LEFT_QUOT: begin
					next_dest = {32'h0000_0000, rot_left & left_mask};
					next_dest_we = 1'b1;
					next_mq_we = 1'b1;
				end
				OP_SHIFT_LEFT_WORD: begin
					next_dest = {32'h0000_0000, rot_left & left_mask};
					next_dest_we = 1'b1;
				end
				OP_SRA_DWORD_REG, OP_SRA_DWORD_IMM: begin
					if (IS_64BIT) begin
						next_dest = next_sra;
						next_carry = next_sra_carry;
						next_dest_we = 1'b1;
						next_carry_we = 1'b1;
					end else begin
						next_illegal = 1'b1;
					end
				end
				OP_SRA_IMM_QUOT: begin
					next_dest = {32'h0000_0000, (rot_quot & quot_mask) | (sign_word & ~quot_mask)};
					next_carry = (|(rot_quot & ~quot_mask)) & source_reg[SIGN_BIT32];
					next_dest_we = 1'b1;
					next_carry_we = 1'b1;
					next_mq_we = 1'b1;
				end
				OP_NONE: begin
				end
			endcase
		end
	end

	// Destination and its write strobe
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dest_reg <= DEST_RESET;
			dest_we <= 1'b0;
			illegal_op <= 1'b0;
		end else begin
			dest_reg <= next_dest;
			dest_we <= next_dest_we;
			illegal_op <= next_illegal;
		end
	end

	// Quotient register holds its value except on quotient operations
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			multiply_quotient_reg <= MQ_RESET;
		end else if (op_valid && next_mq_we) begin
			multiply_quotient_reg <= (op_code == OP_SRA_IMM_QUOT) ? rot_quot : rot_left;
		end
	end

	// Carry only written by right shifts; left shifts leave it alone
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			shifted_out_flag <= 1'b0;
			carry_we <= 1'b0;
		end else begin
			shifted_out_flag <= next_carry;
			carry_we <= next_carry_we;
		end
	end

	// Condition field follows the written result when recording
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cond_field_zero <= CR_RESET;
			cond_we <= 1'b0;
		end else if (next_dest_we && record_bit) begin
			cond_field_zero <= cond_of(next_dest, summary_overflow_in);
			cond_we <= 1'b1;
		end else begin
			cond_we <= 1'b0;
		end
	end

	// Left shifts: carry untouched, plain result checked apart from the shared rotator, quotient result against the quotient register
	left_no_carry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && (op_code inside {OP_SHIFT_LEFT_QUOT, OP_SHIFT_LEFT_WORD})
		|=> !carry_we && $stable(shifted_out_flag))
		else $error("left shift touched carry");
	maskoff_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && (op_code inside {OP_SHIFT_LEFT_QUOT, OP_SHIFT_LEFT_WORD}) && mask_off
		|=> dest_reg == 64'h0000_0000_0000_0000)
		else $error("mask off did not zero result");
	// Rotated word AND the open mask is just a plain left shift, so no rotator is reused
	left_shift_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && (op_code inside {OP_SHIFT_LEFT_QUOT, OP_SHIFT_LEFT_WORD}) && !mask_off
		|=> dest_reg == {32'h0000_0000, $past(source_reg[31:0]) << $past(cnt5)})
		else $error("left shift result mismatch");
	quot_left_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && op_code == OP_SHIFT_LEFT_QUOT
		|=> dest_reg == {32'h0000_0000, multiply_quotient_reg &
		($past(mask_off) ? 32'h0000_0000 : 32'hFFFF_FFFF << $past(cnt5))})
		else $error("quotient left result mismatch");
	mq_rotate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && op_code == OP_SHIFT_LEFT_QUOT
		|=> multiply_quotient_reg == (($past(source_reg[31:0]) << $past(cnt5)) |
		($past(source_reg[31:0]) >> (6'h20 - {1'b0, $past(cnt5)}))))
		else $error("quotient register not the rotated word");
	mq_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && op_code == OP_SHIFT_LEFT_WORD
		|=> $stable(multiply_quotient_reg))
		else $error("plain shift altered quotient register");

	// 64-bit right shifts: copy, sign fill, carry and write strobes
	zero_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && IS_64BIT && (op_code inside {OP_SRA_DWORD_REG, OP_SRA_DWORD_IMM}) && dcount == 7'h00
		|=> dest_reg == $past(source_reg) && !shifted_out_flag && carry_we)
		else $error("zero shift not a copy");
	big_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && IS_64BIT && op_code == OP_SRA_DWORD_REG && dcount[6]
		|=> dest_reg == {64{$past(source_reg[63])}} && shifted_out_flag == $past(source_reg[63]))
		else $error("large count result wrong");
	sign_fill_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && IS_64BIT && (op_code inside {OP_SRA_DWORD_REG, OP_SRA_DWORD_IMM}) && dcount != 7'h00 && !dcount[6]
		|=> dest_reg == 64'($signed($past(source_reg)) >>> $past(dcount[5:0])))
		else $error("right shift result wrong");
	pos_carry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && IS_64BIT && (op_code inside {OP_SRA_DWORD_REG, OP_SRA_DWORD_IMM}) && !source_reg[63]
		|=> !shifted_out_flag)
		else $error("carry set for positive source");
	one_bit_carry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && IS_64BIT && (op_code inside {OP_SRA_DWORD_REG, OP_SRA_DWORD_IMM}) && source_reg[63] && dcount == 7'h01
		|=> shifted_out_flag == $past(source_reg[0]))
		else $error("carry does not follow the lost bit");
	sra_writes_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && IS_64BIT && (op_code inside {OP_SRA_DWORD_REG, OP_SRA_DWORD_IMM})
		|=> carry_we && dest_we && !illegal_op)
		else $error("right shift did not write carry");
	illegal_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && !IS_64BIT && (op_code inside {OP_SRA_DWORD_REG, OP_SRA_DWORD_IMM})
		|=> illegal_op && !dest_we && !carry_we)
		else $error("missing illegal instruction");

	// Immediate quotient right: rotating left by 32 minus N is rotating right by N
	quot_right_mq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && op_code == OP_SRA_IMM_QUOT
		|=> multiply_quotient_reg == (($past(source_reg[31:0]) >> $past(immediate_count[4:0])) |
		($past(source_reg[31:0]) << (6'h20 - {1'b0, $past(immediate_count[4:0])}))))
		else $error("quotient right rotated word wrong");
	quot_right_dest_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && op_code == OP_SRA_IMM_QUOT
		|=> dest_reg[31:0] == ($past(source_reg[31]) ?
		(multiply_quotient_reg | ~(32'hFFFF_FFFF >> $past(immediate_count[4:0]))) :
		(multiply_quotient_reg & (32'hFFFF_FFFF >> $past(immediate_count[4:0])))))
		else $error("quotient right merge wrong");
	quot_carry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && op_code == OP_SRA_IMM_QUOT
		|=> carry_we && shifted_out_flag == ($past(source_reg[31]) &&
		(($past(source_reg[31:0]) << (6'h20 - {1'b0, $past(immediate_count[4:0])})) != 32'h0000_0000)))
		else $error("quotient right carry wrong");

	// Condition field: written only on record, one compare bit, overflow copied
	no_record_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && !record_bit
		|=> !cond_we && $stable(cond_field_zero))
		else $error("condition field changed without record");
	idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!op_valid
		|=> !dest_we && !carry_we && !cond_we && $stable(cond_field_zero) && $stable(dest_reg))
		else $error("state changed with no operation");
	cond_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && record_bit && (op_code inside {OP_SHIFT_LEFT_QUOT, OP_SHIFT_LEFT_WORD, OP_SRA_IMM_QUOT})
		|=> cond_we && $onehot(cond_field_zero[3:1]) && cond_field_zero[0] == $past(summary_overflow_in))
		else $error("condition field not one compare bit");
	cond_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_valid && record_bit && (op_code inside {OP_SHIFT_LEFT_QUOT, OP_SHIFT_LEFT_WORD, OP_SRA_IMM_QUOT})
		|=> cond_field_zero[1] == (dest_reg == 64'h0000_0000_0000_0000))
		else $error("zero bit disagrees with result");

	// Main scenarios
	cover_left_rec_c: cover property (@(posedge ref_clk) op_valid && op_code == OP_SHIFT_LEFT_QUOT && record_bit);
	cover_sra_carry_c: cover property (@(posedge ref_clk) carry_we && shifted_out_flag);
	cover_quot_imm_c: cover property (@(posedge ref_clk) op_valid && op_code == OP_SRA_IMM_QUOT);
	cover_big_count_c: cover property (@(posedge ref_clk) op_valid && op_code == OP_SRA_DWORD_REG && dcount[6]);
	cover_refused_c: cover property (@(posedge ref_clk) illegal_op);
endmodule : fixed_point_shift_unit

/* rtl/shift_mask_gen.sv */
// Left-shift mask generator: 32-N ones then N zeros, or all zeros when forced.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ns
module shift_mask_gen (
	input wire logic [4:0] count, // Shift count N
	input wire logic force_zero, // Mask-off select
	output logic [31:0] mask // Generated mask
);
	import shift_unit_pkg::*;

	// Ones shifted up by N leave N low zeros
	always_comb begin
		if (force_zero) begin
			mask = 32'h0000_0000;
		end else begin
			mask = 32'hFFFF_FFFF << count;
		end
	end
endmodule : shift_mask_gen

/* shared/shift_unit_pkg.sv */
// Package for the fixed-point shift unit: operation codes, field positions, widths.
// Assumes the decoder presents one operation per cycle with operands already read.
package shift_unit_pkg;
	localparam int WORD_W = 32;
	localparam int DWORD_W = 64;
	localparam int CNT_W = 5;
	localparam int DCNT_W = 7;
	// Amount register fields, big-endian bit numbering 0..31 (0 is the msb)
	localparam int AMT_COUNT_LSB = 0; // bits 27-31
	localparam int AMT_MASKOFF_BIT = 5; // bit 26
	localparam int AMT_DCOUNT_LSB = 0; // low seven bits
	localparam int SIGN_BIT64 = 63; // bit 0 in big-endian numbering
	localparam int SIGN_BIT32 = 31;
	localparam int QUOT_ROT_BASE = 32; // rotate amount is 32 minus N
	localparam logic [3:0] CR_RESET = 4'h0;
	localparam logic [31:0] MQ_RESET = 32'h0000_0000;
	localparam logic [63:0] DEST_RESET = 64'h0000_0000_0000_0000;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_SHIFT_LEFT_QUOT,
		OP_SHIFT_LEFT_WORD,
		OP_SRA_DWORD_REG,
		OP_SRA_DWORD_IMM,
		OP_SRA_IMM_QUOT
	} shift_op_type;
endpackage : shift_unit_pkg

/* tb/fixed_point_shift_unit_tb.sv */
// Self-checking bench for the fixed-point shift unit, wide and narrow builds.
// Assumes results and write pulses appear at the taking edge, before the next falling edge.
`timescale 1ns/1ns
module fixed_point_shift_unit_tb;
	import shift_unit_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic issue = 1'b0;
	shift_op_type req_code = OP_NONE;
	logic req_rec = 1'b0;
	logic so_in = 1'b0;
	logic [63:0] req_src = 64'h0;
	logic [63:0] req_amt = 64'h0;
	logic [6:0] req_imm = 7'h00;
	logic op_valid, record_bit, dest_we, carry_we, cond_we, illegal_op, shifted_out_flag, n_dest_we, n_illegal;
	shift_op_type op_code;
	logic [63:0] source_reg, amount_reg, dest_reg;
	logic [6:0] immediate_count;
	logic [31:0] multiply_quotient_reg;
	logic [3:0] cond_field_zero;
	logic [31:0] exp_mq = 32'h0;
	logic exp_carry = 1'b0;
	logic [3:0] exp_cond = 4'h0;
	logic [6:0] cnts [6] = '{7'h00, 7'h01, 7'h05, 7'h3F, 7'h40, 7'h7F};
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	operand_feeder feeder (.issue(issue), .req_code(req_code), .req_rec(req_rec), .req_src(req_src),
		.req_amt(req_amt), .req_imm(req_imm), .op_valid(op_valid), .op_code(op_code), .record_bit(record_bit),
		.source_reg(source_reg), .amount_reg(amount_reg), .immediate_count(immediate_count));
	fixed_point_shift_unit dut (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
		.record_bit(record_bit), .source_reg(source_reg), .amount_reg(amount_reg),
		.immediate_count(immediate_count), .summary_overflow_in(so_in), .dest_reg(dest_reg), .dest_we(dest_we),
		.multiply_quotient_reg(multiply_quotient_reg), .shifted_out_flag(shifted_out_flag), .carry_we(carry_we),
		.cond_field_zero(cond_field_zero), .cond_we(cond_we), .illegal_op(illegal_op));
	// Narrow build shares the operand buses; only its refusal and destination write pulses are watched
	fixed_point_shift_unit #(.IS_64BIT(1'b0)) dut_narrow (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid),
		.op_code(op_code), .record_bit(record_bit), .source_reg(source_reg), .amount_reg(amount_reg),
		.immediate_count(immediate_count), .summary_overflow_in(so_in), .dest_reg(), .dest_we(n_dest_we),
		.multiply_quotient_reg(), .shifted_out_flag(), .carry_we(), .cond_field_zero(), .cond_we(),
		.illegal_op(n_illegal));

	// Clock, 50 ns period
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic finish_test();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	// Hang guard, well above the 50 or so cycles the tests need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Drives one request at a falling edge; back to back, checked one cycle later
	task automatic op(input logic v, input shift_op_type code, input logic rec, input logic [63:0] src,
		input logic [63:0] amt, input logic [6:0] imm);
		logic [63:0] r64;
		logic [63:0] q64;
		logic [31:0] qmask;
		logic [63:0] res;
		logic [6:0] n;
		logic live;
		logic is_sra;
		logic has_ca;
		live = v && (code != OP_NONE);
		is_sra = v && (code == OP_SRA_DWORD_REG || code == OP_SRA_DWORD_IMM);
		has_ca = is_sra || (live && code == OP_SRA_IMM_QUOT);
		r64 = {src[31:0], src[31:0]} << amt[4:0];
		res = {32'h0, r64[63:32] & (amt[5] ? 32'h0 : 32'hFFFFFFFF << amt[4:0])};
		if (live && code == OP_SHIFT_LEFT_QUOT) exp_mq = r64[63:32];
		if (is_sra) begin
			n = (code == OP_SRA_DWORD_REG) ? amt[6:0] : imm;
			res = $signed(src) >>> n;
			exp_carry = src[63] & (|(src & ((64'h1 << n) - 64'h1)));
		end
		// Rotate left by 32 minus N is a rotate right by N; mask is N zeros then ones
		if (live && code == OP_SRA_IMM_QUOT) begin
			q64 = {src[31:0], src[31:0]} >> imm[4:0];
			qmask = 32'hFFFFFFFF >> imm[4:0];
			res = {32'h0, (q64[31:0] & qmask) | ({32{src[31]}} & ~qmask)};
			exp_mq = q64[31:0];
			exp_carry = src[31] & (|(q64[31:0] & ~qmask));
		end
		if (rec && live) exp_cond = {res[63], !res[63] && (res != 64'h0), res == 64'h0, so_in};
		issue = v;
		req_code = code;
		req_rec = rec;
		req_src = src;
		req_amt = amt;
		req_imm = imm;
		@(negedge ref_clk);
		chk({dest_we, carry_we, cond_we, illegal_op}, {live, has_ca, rec && live, 1'b0});
		if (live) chk(dest_reg, res);
		chk({multiply_quotient_reg, shifted_out_flag, cond_field_zero}, {exp_mq, exp_carry, exp_cond});
		chk({n_illegal, n_dest_we}, {is_sra, live && !is_sra});
	endtask : op

	// Main sequence: reset, left shifts, right shift table, quotient rights, idle and no-op
	initial begin
		repeat (16) @(negedge ref_clk);
		chk(dest_reg, 64'h0);
		chk({multiply_quotient_reg, cond_field_zero, shifted_out_flag, dest_we, carry_we, cond_we, illegal_op}, 64'h0);
		rst_n = 1'b1;
		op(1'b1, OP_SHIFT_LEFT_QUOT, 1'b1, 64'h90003000, 64'h24, 7'h00);
		op(1'b1, OP_SHIFT_LEFT_QUOT, 1'b1, 64'hB0043000, 64'h4, 7'h00);
		so_in = 1'b1;
		op(1'b1, OP_SHIFT_LEFT_WORD, 1'b1, 64'hFFFFFFFF, 64'h2F, 7'h00);
		op(1'b1, OP_SHIFT_LEFT_WORD, 1'b0, 64'hB0043000, 64'h5, 7'h00);
		op(1'b1, OP_SHIFT_LEFT_WORD, 1'b1, 64'hFFFF0000_80000001, 64'h1F, 7'h00);
		op(1'b1, OP_SHIFT_LEFT_QUOT, 1'b0, 64'h12345678, 64'h0, 7'h00);
		so_in = 1'b0;
		foreach (cnts[i]) begin
			for (int j = 0; j < 4; j++) begin
				op(1'b1, j[1] ? OP_SRA_DWORD_IMM : OP_SRA_DWORD_REG, j[0] ^ j[1],
					j[0] ? 64'h80000000_00000F03 : 64'h70000000_000000F1,
					{57'h0ABC, j[1] ? ~cnts[i] : cnts[i]}, cnts[i]);
			end
		end
		op(1'b1, OP_SRA_IMM_QUOT, 1'b1, 64'h9000300F, 64'h0, 7'h04);
		op(1'b1, OP_SRA_IMM_QUOT, 1'b0, 64'hB0043000, 64'h0, 7'h04);
		op(1'b0, OP_SHIFT_LEFT_QUOT, 1'b1, 64'h1, 64'h1, 7'h01);
		op(1'b1, OP_NONE, 1'b1, 64'h1, 64'h1, 7'h01);
		issue = 1'b0;
		finish_test();
	end
endmodule : fixed_point_shift_unit_tb

/* tb/operand_feeder.sv */
// Model of the decoder and register file that present operands to the shift unit.
// Assumes the bench changes the request fields at the falling clock edge.
`timescale 1ns/1ns
module operand_feeder (
	input wire logic issue, // Request present
	input wire shift_unit_pkg::shift_op_type req_code, // Decoded operation
	input wire logic req_rec, // Record form
	input wire logic [63:0] req_src, // Source register value
	input wire logic [63:0] req_amt, // Amount register value
	input wire logic [6:0] req_imm, // Immediate count field
	output logic op_valid, // Operation present
	output shift_unit_pkg::shift_op_type op_code, // Operation to unit
	output logic record_bit, // Record form to unit
	output logic [63:0] source_reg, // Source operand bus
	output logic [63:0] amount_reg, // Amount operand bus
	output logic [6:0] immediate_count // Immediate count bus
);
	import shift_unit_pkg::*;
	// Idle operand buses carry inverted data so stale values are never trusted
	always_comb begin
		op_valid = issue;
		op_code = req_code;
		record_bit = req_rec;
		source_reg = issue ? req_src : ~req_src;
		amount_reg = issue ? req_amt : ~req_amt;
		immediate_count = issue ? req_imm : ~req_imm;
	end
endmodule : operand_feeder
